// ---- pca_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pca_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic svc_en,
    input wire logic [7:0] rd_byte_q,
    input wire logic rd_byte_valid,
    output logic rd_byte_ready,
    input wire logic alert_line_low_q,
    output logic ara_req
);
    logic [7:0] rx [$];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_byte_ready <= 1'b0;
            ara_req <= 1'b0;
        end else begin
            // Slow host stalls every other cycle
            rd_byte_ready <= slow ? ~rd_byte_ready : 1'b1;
            // Keeps querying the alert address while the line stays low
            ara_req <= svc_en & alert_line_low_q;
            if (rd_byte_valid && rd_byte_ready) begin
                rx.push_back(rd_byte_q);
            end
        end
    end
endmodule
`default_nettype wire

// ---- pca_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
// Byte store with registered read; the array itself has no reset
module pca_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << AW) || WIDTH < 1) begin
            $error("pca_mem: depth does not fit the address width");
        end
    end

    // Contents survive reset, standing in for the retained store
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ---- pca_param_capture.sv ----
// Behaviour
// - Config write bit 1 set enables capture, cleared disables it.
// - Captured record leaves as one block read of 32 data bytes.
// - While enabled, each firmware cycle refreshes the record in RAM.
// - Store command 1 copies the flash record into RAM.
// - Store command 2 writes RAM record to flash, only while disabled.
// - A fault set to shut down writes the record to flash automatically.
// - A fault set to retry causes no automatic flash write.
// - A flash write of the record finishes within 1400 us.
// - Flash record survives power cycle for later copy and read.
// - Alert line is pulled low whenever a configured fault occurs.
// - Live voltages, current, temperatures, frequency, duty always readable.
`timescale 1ns/1ns
`default_nettype none
module pca_param_capture #(
    parameter int NUM_FAULT = 8,
    parameter int FLASH_WR_MAX_CYC = pca_pkg::FLASH_WR_MAX_US * pca_pkg::CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic misc_cfg_wr,
    input wire logic [7:0] misc_cfg_data,
    input wire logic store_cmd_wr,
    input wire logic [7:0] store_cmd_data,
    input wire logic module_enabled,
    input wire logic fw_cycle_tick,
    input wire logic [pca_pkg::MON_W*pca_pkg::NUM_MON-1:0] live_params,
    input wire logic [NUM_FAULT-1:0] fault_in,
    input wire logic [NUM_FAULT-1:0] fault_shutdown,
    input wire logic clear_faults,
    input wire logic [pca_pkg::MON_SEL_W-1:0] mon_sel,
    output logic [pca_pkg::MON_W-1:0] mon_data_q,
    input wire logic blk_rd_start,
    output logic [7:0] rd_byte_q,
    output logic rd_byte_valid,
    input wire logic rd_byte_ready,
    output logic rd_done,
    output logic capture_en_q,
    output logic flash_busy,
    output logic [NUM_FAULT-1:0] fault_flags_q,
    output logic fault_alert_line_n_out,
    output logic fault_alert_line_n_oe,
    input wire logic fault_alert_line_n_in,
    output logic alert_line_low_q,
    input wire logic ara_req,
    output logic ara_ack
);
    import pca_pkg::*;

    initial begin
        if (NUM_FAULT < 1 || NUM_FAULT > MON_W) begin
            $error("pca_param_capture: NUM_FAULT must be 1 to 16");
        end
        if (FLASH_WR_MAX_CYC < REC_BYTES + 2) begin
            $error("pca_param_capture: FLASH_WR_MAX_CYC too small for a record");
        end
    end

    pca_state_type state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic load_pend_q, save_pend_q, read_pend_q, cap_pend_q;
    logic rd_wait_q;
    logic [NUM_FAULT-1:0] fault_prev_q;
    logic [2:0] alert_sync_q;
    logic [31:0] save_cyc_q;

    // Command decode
    wire cmd_load = store_cmd_wr && (store_cmd_data == STORE_CMD_LOAD);
    wire cmd_save = store_cmd_wr && (store_cmd_data == STORE_CMD_SAVE) && !module_enabled;
    wire [NUM_FAULT-1:0] fault_rise = fault_in & ~fault_prev_q;
    wire shut_hit = |(fault_rise & fault_shutdown);

    wire in_idle = (state_q == ST_IDLE);
    wire in_cap = (state_q == ST_CAP);
    wire in_load = (state_q == ST_LOAD);
    wire in_save = (state_q == ST_SAVE);
    wire in_read = (state_q == ST_READ);

    // Idle arbitration: save, then load, then block read, then refresh
    wire go_save = in_idle && save_pend_q;
    wire go_load = in_idle && !save_pend_q && load_pend_q;
    wire go_read = in_idle && !save_pend_q && !load_pend_q && read_pend_q;
    wire go_cap = in_idle && !save_pend_q && !load_pend_q && !read_pend_q
        && cap_pend_q && capture_en_q;

    wire rd_xfer = rd_byte_valid && rd_byte_ready;
    wire rd_last = in_read && rd_xfer && (cnt_q == REC_CNT);
    wire copy_wr = (in_load || in_save) && (cnt_q != CNT_ZERO);
    wire [REC_AW-1:0] copy_waddr = REC_AW'(cnt_q - CNT_ONE);

    // Live record image: parameters, then latched fault word, then zeros
    wire [REC_BITS-1:0] live_rec = REC_BITS'({MON_W'(fault_flags_q), live_params});
    wire [7:0] live_byte = live_rec[{cnt_q[REC_AW-1:0], 3'h0} +: 8];

    wire [7:0] ram_rdata;
    wire [7:0] flash_rdata;
    wire ram_we = in_cap || (in_load && copy_wr);
    wire [REC_AW-1:0] ram_waddr = in_cap ? cnt_q[REC_AW-1:0] : copy_waddr;
    wire [7:0] ram_wdata = in_cap ? live_byte : flash_rdata;
    wire flash_we = in_save && copy_wr;

    pca_mem #(.WIDTH(8), .DEPTH(REC_BYTES), .AW(REC_AW)) u_ram (
        .clk(clk),
        .rst(rst),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(cnt_q[REC_AW-1:0]),
        .rdata_q(ram_rdata)
    );

    pca_mem #(.WIDTH(8), .DEPTH(REC_BYTES), .AW(REC_AW)) u_flash (
        .clk(clk),
        .rst(rst),
        .we(flash_we),
        .waddr(copy_waddr),
        .wdata(ram_rdata),
        .raddr(cnt_q[REC_AW-1:0]),
        .rdata_q(flash_rdata)
    );

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (go_save) begin
                    state_d = ST_SAVE;
                    cnt_d = CNT_ZERO;
                end else if (go_load) begin
                    state_d = ST_LOAD;
                    cnt_d = CNT_ZERO;
                end else if (go_read) begin
                    state_d = ST_READ;
                    cnt_d = CNT_ZERO;
                end else if (go_cap) begin
                    state_d = ST_CAP;
                    cnt_d = CNT_ZERO;
                end
            end
            ST_CAP: begin
                if (cnt_q == CAP_LAST) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            ST_LOAD, ST_SAVE: begin
                if (cnt_q == REC_CNT) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            ST_READ: begin
                if (rd_last) begin
                    state_d = ST_IDLE;
                end else if (rd_wait_q) begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Pending requests; a new request wins over the clear of its flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_pend_q <= 1'b0;
            save_pend_q <= 1'b0;
            read_pend_q <= 1'b0;
            cap_pend_q <= 1'b0;
        end else begin
            load_pend_q <= cmd_load || (load_pend_q && !go_load);
            save_pend_q <= cmd_save || shut_hit || (save_pend_q && !go_save);
            read_pend_q <= blk_rd_start || (read_pend_q && !go_read);
            cap_pend_q <= (fw_cycle_tick && capture_en_q)
                || (cap_pend_q && !go_cap && capture_en_q);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_en_q <= 1'b0;
        end else if (misc_cfg_wr) begin
            capture_en_q <= misc_cfg_data[CAP_EN_BIT];
        end
    end

    // Block read: count byte first, then record bytes with one-cycle fetch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_byte_q <= BYTE_ZERO;
            rd_byte_valid <= 1'b0;
            rd_wait_q <= 1'b0;
        end else if (go_read) begin
            rd_byte_q <= BLK_COUNT_BYTE;
            rd_byte_valid <= 1'b1;
        end else if (rd_last) begin
            rd_byte_valid <= 1'b0;
        end else if (in_read && rd_xfer) begin
            rd_byte_valid <= 1'b0;
            rd_wait_q <= 1'b1;
        end else if (rd_wait_q) begin
            rd_byte_q <= ram_rdata;
            rd_byte_valid <= 1'b1;
            rd_wait_q <= 1'b0;
        end
    end

    assign rd_done = rd_last;
    assign flash_busy = in_load || in_save;

    wire mon_ok = (mon_sel < MON_SEL_W'(NUM_MON));
    wire [MON_W-1:0] mon_d = mon_ok ? live_params[{mon_sel, 4'h0} +: MON_W] : MON_NONE;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mon_data_q <= MON_NONE;
        end else begin
            mon_data_q <= mon_d;
        end
    end

    // Fault latch and alert drive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_prev_q <= '0;
            fault_flags_q <= '0;
        end else begin
            fault_prev_q <= fault_in;
            fault_flags_q <= fault_rise | (fault_flags_q & ~{NUM_FAULT{clear_faults}});
        end
    end

    assign fault_alert_line_n_out = 1'b0;
    assign fault_alert_line_n_oe = |fault_flags_q;
    assign ara_ack = ara_req && fault_alert_line_n_oe;

    // Shared line level, three-stage synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_sync_q <= 3'h7;
            alert_line_low_q <= 1'b0;
        end else begin
            alert_sync_q <= {alert_sync_q[1:0], fault_alert_line_n_in};
            if (alert_sync_q[1] == alert_sync_q[2]) begin
                alert_line_low_q <= !alert_sync_q[2];
            end
        end
    end

    // Helper: cycles spent writing flash
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            save_cyc_q <= '0;
        end else if (in_save) begin
            save_cyc_q <= save_cyc_q + 32'h1;
        end else begin
            save_cyc_q <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    cap_enable_a: assert property (misc_cfg_wr
        |=> capture_en_q == $past(misc_cfg_data[CAP_EN_BIT]))
        else $error("capture enable does not follow bit 1");
    blk_count_a: assert property (go_read
        |=> rd_byte_valid && rd_byte_q == BLK_COUNT_BYTE ##0 in_read)
        else $error("block read does not open with count 32");
    cap_refresh_a: assert property (go_cap
        |=> (in_cap && cnt_q == CNT_ZERO) ##31 (in_cap && cnt_q == CAP_LAST) ##1 in_idle)
        else $error("refresh does not write 32 bytes");
    load_cmd_a: assert property (cmd_load && !in_idle |=> load_pend_q)
        else $error("copy to RAM request lost");
    save_gate_a: assert property (store_cmd_wr && store_cmd_data == STORE_CMD_SAVE
        && module_enabled
        && !shut_hit && !save_pend_q |=> !save_pend_q)
        else $error("flash write taken while enabled");
    auto_save_a: assert property (shut_hit |=> save_pend_q || in_save)
        else $error("shutdown fault did not request flash write");
    retry_nosave_a: assert property (!shut_hit && !cmd_save && !save_pend_q |=> !save_pend_q)
        else $error("flash write without shutdown fault or command");
    save_time_a: assert property (save_cyc_q < FLASH_WR_MAX_CYC)
        else $error("flash write too long");
    save_len_a: assert property (go_save
        |=> in_save ##32 (in_save && save_cyc_q == 32'(REC_CNT)) ##1 in_idle)
        else $error("flash write length wrong");
    alert_drive_a: assert property (|fault_rise |=> fault_alert_line_n_oe && !fault_alert_line_n_out)
        else $error("alert not driven low on fault");
    ignore_cmd_a: assert property (store_cmd_wr && store_cmd_data != STORE_CMD_LOAD
        && store_cmd_data != STORE_CMD_SAVE && !shut_hit && !save_pend_q && !load_pend_q
        |=> !save_pend_q && !load_pend_q)
        else $error("unknown store command acted on");
endmodule
`default_nettype wire

// ---- pca_pkg.sv ----
`default_nettype none
package pca_pkg;
    // Record geometry
    localparam int REC_BYTES = 32;
    localparam int REC_AW = 5;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] CAP_LAST = 6'h1F;
    localparam logic [CNT_W-1:0] REC_CNT = 6'h20;
    localparam logic [7:0] BLK_COUNT_BYTE = 8'h20;
    localparam int REC_BITS = 256;

    // Live parameters: vin, vout, iout, temp_int, temp_ext, freq, duty
    localparam int MON_W = 16;
    localparam int NUM_MON = 7;
    localparam int MON_SEL_W = 3;
    localparam logic [MON_W-1:0] MON_NONE = 16'h0000;

    // Command fields
    localparam int CAP_EN_BIT = 1;
    localparam logic [7:0] STORE_CMD_LOAD = 8'h01;
    localparam logic [7:0] STORE_CMD_SAVE = 8'h02;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Flash write time limit
    localparam int FLASH_WR_MAX_US = 1400;
    localparam int CLK_MHZ = 100;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CAP = 5'h02,
        ST_LOAD = 5'h04,
        ST_SAVE = 5'h08,
        ST_READ = 5'h10
    } pca_state_type;
endpackage
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import pca_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic misc_cfg_wr = 1'b0, store_cmd_wr = 1'b0, module_enabled = 1'b0;
    logic fw_cycle_tick = 1'b0, clear_faults = 1'b0, blk_rd_start = 1'b0;
    logic slow = 1'b0, svc_en = 1'b0;
    logic [7:0] misc_cfg_data = 8'h00, store_cmd_data = 8'h00;
    logic [7:0] fault_in = 8'h00, fault_shutdown = 8'h00;
    logic [MON_W*NUM_MON-1:0] live_params = '0;
    logic [MON_W*NUM_MON-1:0] pat_a = 112'h0123_4567_89AB_CDEF_FEDC_BA98_7654;
    logic [2:0] mon_sel = 3'h0;
    logic [15:0] mon_data_q;
    logic [7:0] rd_byte_q, fault_flags_q;
    logic rd_byte_valid, rd_byte_ready, rd_done, capture_en_q, flash_busy;
    logic alert_out, alert_oe, alert_line_low_q, ara_req, ara_ack;
    wire logic alert_wire;
    int error_cnt = 0;
    int checks_done = 0;
    int done_seen = 0;

    // Shared alert line with pull-up
    assign alert_wire = alert_oe ? alert_out : 1'b1;
    always #5 clk = ~clk;

    // Counts end-of-read pulses as the design shows them at each edge
    always @(posedge clk) begin
        if (rd_done === 1'b1) begin
            done_seen++;
        end
    end

    pca_param_capture #(.NUM_FAULT(8), .FLASH_WR_MAX_CYC(40)) dut (
        .clk, .rst, .misc_cfg_wr, .misc_cfg_data, .store_cmd_wr, .store_cmd_data,
        .module_enabled, .fw_cycle_tick, .live_params, .fault_in, .fault_shutdown,
        .clear_faults, .mon_sel, .mon_data_q, .blk_rd_start, .rd_byte_q, .rd_byte_valid,
        .rd_byte_ready, .rd_done, .capture_en_q, .flash_busy, .fault_flags_q,
        .fault_alert_line_n_out(alert_out), .fault_alert_line_n_oe(alert_oe),
        .fault_alert_line_n_in(alert_wire), .alert_line_low_q, .ara_req, .ara_ack
    );

    pca_host_model host (
        .clk, .rst, .slow, .svc_en, .rd_byte_q, .rd_byte_valid, .rd_byte_ready,
        .alert_line_low_q, .ara_req
    );

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task cfg(input logic [7:0] d);
        misc_cfg_data = d;
        misc_cfg_wr = 1'b1;
        cyc(1);
        misc_cfg_wr = 1'b0;
        chk(16'(capture_en_q), 16'(d[CAP_EN_BIT]));
    endtask

    task flash_op(input logic [7:0] d, input logic run);
        int n;
        store_cmd_data = d;
        store_cmd_wr = 1'b1;
        cyc(1);
        store_cmd_wr = 1'b0;
        cyc(1);
        n = 0;
        while (flash_busy === 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk(16'(n), run ? 16'h0021 : 16'h0000);
    endtask

    task refresh(input logic [MON_W*NUM_MON-1:0] lp);
        live_params = lp;
        cfg(8'h02);
        fw_cycle_tick = 1'b1;
        cyc(1);
        fw_cycle_tick = 1'b0;
        cyc(40);
        // Capture off before fetching so RAM is not overwritten
        cfg(8'hFD);
    endtask

    task read_check(input logic [MON_W*NUM_MON-1:0] lp);
        int n;
        int d0;
        host.rx.delete();
        d0 = done_seen;
        blk_rd_start = 1'b1;
        cyc(1);
        blk_rd_start = 1'b0;
        n = 0;
        while (host.rx.size() < 33 && n < 400) begin
            cyc(1);
            n++;
        end
        chk(16'(host.rx.size()), 16'h0021);
        chk(16'(done_seen - d0), 16'h0001);
        chk(16'(rd_byte_valid), 16'h0000);
        chk(16'(host.rx[0]), 16'(BLK_COUNT_BYTE));
        for (int i = 0; i < 32; i++) begin
            chk(16'(host.rx[i+1]), i < 14 ? 16'(lp[8*i +: 8]) : 16'h0000);
        end
    endtask

    task t_monitor;
        for (int i = 0; i < 8; i++) begin
            mon_sel = 3'(i);
            cyc(1);
            chk(mon_data_q, i < 7 ? live_params[16*i +: 16] : MON_NONE);
        end
    endtask

    task t_capture_store;
        slow = 1'b1;
        refresh(pat_a);
        read_check(pat_a);
        flash_op(STORE_CMD_SAVE, 1'b1);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        refresh(~pat_a);
        read_check(~pat_a);
        flash_op(STORE_CMD_LOAD, 1'b1);
        read_check(pat_a);
        slow = 1'b0;
    endtask

    task t_refused;
        logic [7:0] bad [4];
        bad = '{8'h00, 8'h03, 8'h05, 8'hFF};
        module_enabled = 1'b1;
        flash_op(STORE_CMD_SAVE, 1'b0);
        foreach (bad[i]) flash_op(bad[i], 1'b0);
        module_enabled = 1'b0;
        read_check(pat_a);
    endtask

    task t_fault;
        svc_en = 1'b1;
        fault_in = 8'h01;
        cyc(1);
        chk(16'(fault_flags_q), 16'h0001);
        chk(16'(alert_oe), 16'h0001);
        chk(16'(alert_out), 16'h0000);
        cyc(5);
        chk(16'(alert_line_low_q), 16'h0001);
        cyc(1);
        chk(16'(ara_ack), 16'h0001);
        chk(16'(flash_busy), 16'h0000);
        fault_in = 8'h00;
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        chk(16'(alert_oe), 16'h0000);
        chk(16'(ara_ack), 16'h0000);
        module_enabled = 1'b1;
        fault_shutdown = 8'h08;
        fault_in = 8'h08;
        cyc(2);
        chk(16'(flash_busy), 16'h0001);
        cyc(40);
        chk(16'(flash_busy), 16'h0000);
        svc_en = 1'b0;
        module_enabled = 1'b0;
    endtask

    task report_and_stop;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        cyc(1);
        live_params = pat_a;
        t_monitor();
        t_capture_store();
        t_refused();
        t_fault();
        report_and_stop();
    end

    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
